// ---- rtl/adm_clk_div.sv ----
// adm_clk_div: conversion clock enable from the peripheral clock.
// assumes: run_i drops between conversions so each starts on a fresh count.
`timescale 1ns/1ps

module adm_clk_div
   import adm_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   // control
   input  wire logic       run_i,
   input  wire logic [1:0] div_sel_i,
   // conversion clock enable
   output      logic       tick_o
);

   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   logic [2:0] last;

   ////////////////////////////////////////////////////////////////////////////
   // divider ratio select
   always_comb begin
      unique case (div_sel_i)
         ADM_DIV_SEL_8: last = ADM_DIV_LAST_8;
         ADM_DIV_SEL_4: last = ADM_DIV_LAST_4;
         ADM_DIV_SEL_2: last = ADM_DIV_LAST_2;
         ADM_DIV_SEL_1: last = ADM_DIV_LAST_1;
      endcase
   end

   assign tick_o = run_i && (cnt_q >= last);

   always_comb begin
      cnt_d = 3'h0;
      if (run_i && !tick_o) begin
         cnt_d = cnt_q + 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

// ---- rtl/adm_pkg.sv ----
// adm_pkg: addresses, field positions, reset values, timing counts and types
// for the successive-approximation converter control block.
// assumes: byte-wide special-function-register bus, one 40 MHz clock.

package adm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [19:0] ADM_CTRL_ADDR      = 20'hfff30;
   localparam logic [19:0] ADM_RES_SEL_ADDR   = 20'hf0010;
   localparam logic [19:0] ADM_RESULT_HI_ADDR = 20'hfff1f;
   localparam logic [19:0] ADM_RESULT_LO_ADDR = 20'hfff1e;

   localparam int ADM_CTRL_START_BIT  = 7;
   localparam int ADM_CTRL_DIV_HI_BIT = 5;
   localparam int ADM_CTRL_DIV_LO_BIT = 4;
   localparam int ADM_CTRL_SAMP_BIT   = 3;
   localparam int ADM_CTRL_ENABLE_BIT = 0;
   localparam int ADM_RES_SEL_BIT     = 0;

   localparam logic [7:0] ADM_REG_RESET    = 8'h00;
   localparam logic [7:0] ADM_UNMAPPED_VAL = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // conversion timing, in conversion clocks
   localparam logic [3:0] ADM_SAMPLE_FAD_LONG  = 4'h7;
   localparam logic [3:0] ADM_SAMPLE_FAD_SHORT = 4'h5;
   localparam logic [3:0] ADM_FINISH_FAD       = 4'h2;
   localparam logic [3:0] ADM_CONV_STATE_FAD   = 4'h2;
   localparam logic [4:0] ADM_CONV_FAD_LONG    = 5'h13;
   localparam logic [4:0] ADM_CONV_FAD_SHORT   = 5'h11;
   localparam logic [3:0] ADM_MSB_INDEX        = 4'h9;
   localparam logic [3:0] ADM_LSB_INDEX_10     = 4'h0;
   localparam logic [3:0] ADM_LSB_INDEX_8      = 4'h2;
   localparam logic [9:0] ADM_SAR_FIRST_TRIAL  = 10'h200;

   ////////////////////////////////////////////////////////////////////////////
   // clock divider selections and terminal counts
   localparam logic [1:0] ADM_DIV_SEL_8 = 2'h0;
   localparam logic [1:0] ADM_DIV_SEL_4 = 2'h1;
   localparam logic [1:0] ADM_DIV_SEL_2 = 2'h2;
   localparam logic [1:0] ADM_DIV_SEL_1 = 2'h3;
   localparam logic [2:0] ADM_DIV_LAST_8 = 3'h7;
   localparam logic [2:0] ADM_DIV_LAST_4 = 3'h3;
   localparam logic [2:0] ADM_DIV_LAST_2 = 3'h1;
   localparam logic [2:0] ADM_DIV_LAST_1 = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      ADM_MODE_STOP       = 2'b00,
      ADM_MODE_STANDBY    = 2'b01,
      ADM_MODE_PROHIBITED = 2'b10,
      ADM_MODE_CONVERT    = 2'b11
   } adm_mode_type;

   typedef enum logic [2:0] {
      ADM_ST_IDLE    = 3'b000,
      ADM_ST_SETUP   = 3'b001,
      ADM_ST_SAMPLE  = 3'b010,
      ADM_ST_COMPARE = 3'b011,
      ADM_ST_FINISH  = 3'b100
   } adm_state_type;

   typedef struct packed {
      logic       conv_start_flag;
      logic [1:0] clock_div_sel;
      logic       sampling_length_sel;
      logic       comparator_enable_flag;
   } adm_ctrl_type;

   localparam adm_ctrl_type ADM_CTRL_RESET = '{1'b0, 2'h0, 1'b0, 1'b0};

endpackage

// ---- rtl/adm_sar_ctrl.sv ----
// adm_sar_ctrl: mode registers, conversion sequencer and result registers
// of the successive-approximation converter.
// assumes: byte register port with one-cycle write and read strobes;
// comparator output compare_i is valid in the clock of each trial.
`timescale 1ns/1ps

module adm_sar_ctrl
   import adm_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // register port
   input  wire logic [19:0] sfr_addr_i,
   input  wire logic [7:0]  sfr_wdata_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   output      logic [7:0]  sfr_rdata_o,
   // comparator and sampling side
   input  wire logic        compare_i,
   output      logic        comparator_power_o,
   output      logic        sample_o,
   output      logic [9:0]  trial_code_o,
   // status
   output      adm_mode_type conv_mode_o,
   output      logic        conversion_done_irq_o
);

   adm_ctrl_type  ctl_q, ctl_d;
   logic          res_q, res_d;
   adm_state_type state_q, state_d;
   logic [3:0]    cnt_q, cnt_d;
   logic [3:0]    bit_q, bit_d;
   logic [9:0]    sar_q, sar_d;
   logic [7:0]    result_hi_q, result_hi_d;
   logic [1:0]    result_lo_q, result_lo_d;
   logic          irq_q, irq_d;
   logic [7:0]    rdata_q, rdata_d;
   logic          tick;
   logic          ctrl_wr;
   logic [3:0]    samp_len;
   logic [3:0]    lsb_index;

   ////////////////////////////////////////////////////////////////////////////
   // conversion clock
   adm_clk_div u_clk_div (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .run_i     (ctl_q.conv_start_flag),
      .div_sel_i (ctl_q.clock_div_sel),
      .tick_o    (tick)
   );

   assign ctrl_wr   = sfr_wr_i && (sfr_addr_i == ADM_CTRL_ADDR);
   assign samp_len  = ctl_q.sampling_length_sel ? ADM_SAMPLE_FAD_SHORT : ADM_SAMPLE_FAD_LONG;
   assign lsb_index = res_q ? ADM_LSB_INDEX_8 : ADM_LSB_INDEX_10;

   ////////////////////////////////////////////////////////////////////////////
   // next state of registers and sequencer
   always_comb begin
      ctl_d       = ctl_q;
      res_d       = res_q;
      state_d     = state_q;
      cnt_d       = cnt_q;
      bit_d       = bit_q;
      sar_d       = sar_q;
      result_hi_d = result_hi_q;
      result_lo_d = result_lo_q;
      irq_d       = 1'b0;
      rdata_d     = rdata_q;

      if (ctrl_wr) begin
         ctl_d.comparator_enable_flag = sfr_wdata_i[ADM_CTRL_ENABLE_BIT];
         ctl_d.clock_div_sel = {sfr_wdata_i[ADM_CTRL_DIV_HI_BIT],
                                sfr_wdata_i[ADM_CTRL_DIV_LO_BIT]};
         ctl_d.sampling_length_sel = sfr_wdata_i[ADM_CTRL_SAMP_BIT];
         ctl_d.conv_start_flag = sfr_wdata_i[ADM_CTRL_START_BIT]
                                 && ctl_q.comparator_enable_flag
                                 && sfr_wdata_i[ADM_CTRL_ENABLE_BIT];
      end
      if (sfr_wr_i && (sfr_addr_i == ADM_RES_SEL_ADDR)) begin
         res_d = sfr_wdata_i[ADM_RES_SEL_BIT];
      end

      if (!ctl_q.conv_start_flag) begin
         state_d = ADM_ST_IDLE;
      end else begin
         unique case (state_q)
            ADM_ST_IDLE: begin
               state_d = ADM_ST_SETUP;
               cnt_d   = 4'h0;
            end
            ADM_ST_SETUP: begin
               if (tick) begin
                  if (cnt_q == ADM_CONV_STATE_FAD - 4'h1) begin
                     state_d = ADM_ST_SAMPLE;
                     cnt_d   = 4'h0;
                  end else begin
                     cnt_d = cnt_q + 4'h1;
                  end
               end
            end
            ADM_ST_SAMPLE: begin
               if (tick) begin
                  if (cnt_q == samp_len - 4'h1) begin
                     state_d = ADM_ST_COMPARE;
                     bit_d   = ADM_MSB_INDEX;
                     sar_d   = ADM_SAR_FIRST_TRIAL;
                  end else begin
                     cnt_d = cnt_q + 4'h1;
                  end
               end
            end
            ADM_ST_COMPARE: begin
               if (tick) begin
                  sar_d[bit_q] = compare_i;
                  // stop at bit 2 in 8-bit mode
                  if (bit_q == lsb_index) begin
                     state_d = ADM_ST_FINISH;
                     cnt_d   = 4'h0;
                  end else begin
                     sar_d[bit_q - 4'h1] = 1'b1;
                     bit_d = bit_q - 4'h1;
                  end
               end
            end
            ADM_ST_FINISH: begin
               if (tick) begin
                  if (cnt_q == ADM_FINISH_FAD - 4'h1) begin
                     result_hi_d = sar_q[9:2];
                     result_lo_d = res_q ? 2'h0 : sar_q[1:0];
                     irq_d       = 1'b1;
                     ctl_d.conv_start_flag = 1'b0;
                     state_d = ADM_ST_IDLE;
                  end else begin
                     cnt_d = cnt_q + 4'h1;
                  end
               end
            end
            default: state_d = ADM_ST_IDLE;
         endcase
      end

      if (sfr_rd_i) begin
         unique case (sfr_addr_i)
            ADM_CTRL_ADDR: begin
               rdata_d = 8'h00;
               rdata_d[ADM_CTRL_START_BIT]  = ctl_q.conv_start_flag;
               rdata_d[ADM_CTRL_DIV_HI_BIT] = ctl_q.clock_div_sel[1];
               rdata_d[ADM_CTRL_DIV_LO_BIT] = ctl_q.clock_div_sel[0];
               rdata_d[ADM_CTRL_SAMP_BIT]   = ctl_q.sampling_length_sel;
               rdata_d[ADM_CTRL_ENABLE_BIT] = ctl_q.comparator_enable_flag;
            end
            ADM_RES_SEL_ADDR: begin
               rdata_d = 8'h00;
               rdata_d[ADM_RES_SEL_BIT] = res_q;
            end
            ADM_RESULT_HI_ADDR: rdata_d = result_hi_q;
            ADM_RESULT_LO_ADDR: rdata_d = {result_lo_q, 6'h00};
            default:            rdata_d = ADM_UNMAPPED_VAL;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ctl_q       <= ADM_CTRL_RESET;
         res_q       <= 1'b0;
         state_q     <= ADM_ST_IDLE;
         cnt_q       <= 4'h0;
         bit_q       <= 4'h0;
         sar_q       <= 10'h000;
         result_hi_q <= ADM_REG_RESET;
         result_lo_q <= 2'h0;
         irq_q       <= 1'b0;
         rdata_q     <= ADM_REG_RESET;
      end else begin
         ctl_q       <= ctl_d;
         res_q       <= res_d;
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         bit_q       <= bit_d;
         sar_q       <= sar_d;
         result_hi_q <= result_hi_d;
         result_lo_q <= result_lo_d;
         irq_q       <= irq_d;
         rdata_q     <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   // comparator runs while enabled
   assign comparator_power_o    = ctl_q.comparator_enable_flag;
   assign conv_mode_o           = adm_mode_type'({ctl_q.conv_start_flag,
                                                  ctl_q.comparator_enable_flag});
   assign sample_o              = (state_q == ADM_ST_SAMPLE);
   assign trial_code_o          = sar_q;
   assign conversion_done_irq_o = irq_q;
   assign sfr_rdata_o           = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic [4:0] fad_seen_q;

   always_ff @(posedge clk_i) begin
      if (reset_i || state_q == ADM_ST_SETUP) begin
         fad_seen_q <= 5'h00;
      end else if (tick && state_q != ADM_ST_IDLE) begin
         fad_seen_q <= fad_seen_q + 5'h01;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_start_write_ignored: assert property (ctrl_wr && !ctl_q.conv_start_flag
         && !ctl_q.comparator_enable_flag |=> !ctl_q.conv_start_flag)
      else $error("start set from stopped state");

   a_mode_never_prohibited: assert property (conv_mode_o != ADM_MODE_PROHIBITED)
      else $error("prohibited start without enable");

   a_div8_tick_spacing: assert property (tick && ctl_q.clock_div_sel == ADM_DIV_SEL_8
         |=> !tick [*7])
      else $error("divide by 8 tick too early");

   a_div1_every_clock: assert property (ctl_q.conv_start_flag
         && $past(ctl_q.conv_start_flag)
         && ctl_q.clock_div_sel == ADM_DIV_SEL_1 |-> tick)
      else $error("undivided clock missed a tick");

   a_long_conv_length: assert property (irq_q && !res_q && !ctl_q.sampling_length_sel
         |-> fad_seen_q == ADM_CONV_FAD_LONG)
      else $error("long conversion length wrong");

   a_short_conv_length: assert property (irq_q && !res_q && ctl_q.sampling_length_sel
         |-> fad_seen_q == ADM_CONV_FAD_SHORT)
      else $error("short conversion length wrong");

   a_setup_before_sample: assert property ($rose(sample_o)
         |-> $past(state_q) == ADM_ST_SETUP)
      else $error("sampling began without state time");

   a_done_stores_result: assert property (irq_q |-> result_hi_q == $past(sar_q[9:2])
         && !ctl_q.conv_start_flag)
      else $error("done without stored result or start clear");

   a_abort_no_result: assert property (state_q != ADM_ST_IDLE && !ctl_q.conv_start_flag
         |=> !irq_q && $stable(result_hi_q))
      else $error("aborted conversion updated result");

   a_eight_bit_stop: assert property (state_q == ADM_ST_COMPARE && res_q && tick
         && bit_q == ADM_LSB_INDEX_8 && ctl_q.conv_start_flag
         |=> state_q == ADM_ST_FINISH)
      else $error("8-bit compare did not stop at bit 2");

   a_res_reads_clean: assert property (sfr_rd_i && sfr_addr_i == ADM_RES_SEL_ADDR
         |=> sfr_rdata_o[7:1] == 7'h00 && sfr_rdata_o[0] == res_q)
      else $error("resolution register read wrong");

endmodule

// ---- verification/adm_comparator_model.sv ----
// adm_comparator_model: behavioural voltage comparator facing the sequencer.
// assumes: analog input given as a 10-bit code, trial code from the design.
`timescale 1ns/1ps

module adm_comparator_model (
   // clock
   input  wire logic       clk_i,
   // analog side
   input  wire logic [9:0] vin_i,
   input  wire logic       power_i,
   input  wire logic [9:0] trial_i,
   // comparator result
   output      logic       compare_o
);
   logic idle_q = 1'b0;
   logic idle_d;

   ////////////////////////////////////////////////////////////////////////////
   // unpowered output wanders every cycle
   always_comb idle_d = ~idle_q;
   always_ff @(posedge clk_i) idle_q <= idle_d;

   assign compare_o = power_i ? (vin_i >= trial_i) : idle_q;
endmodule

// ---- verification/sar_adc_mode_control_bench.sv ----
// sar_adc_mode_control_bench: register-level tests of the converter control.
// assumes: comparator model on the far side, 40 MHz clock.
`timescale 1ns/1ps

module sar_adc_mode_control_bench
   import adm_pkg::*;
;

   logic         clk_i   = 1'b0;
   logic         reset_i = 1'b1;
   logic [19:0]  addr    = 20'h0;
   logic [7:0]   wdata   = 8'h00;
   logic         wr      = 1'b0;
   logic         rd      = 1'b0;
   logic [9:0]   vin     = 10'h000;
   logic [7:0]   rdata;
   logic         cmp;
   logic         power;
   logic         sample;
   logic [9:0]   trial;
   adm_mode_type mode;
   logic         irq;
   int           n_mismatch  = 0;
   int           comparisons = 0;
   int           cyc;
   int           smp;
   int           d;
   logic         seen;

   always #12.5 clk_i = ~clk_i;

   adm_sar_ctrl dut (.clk_i(clk_i), .reset_i(reset_i), .sfr_addr_i(addr),
      .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
      .compare_i(cmp), .comparator_power_o(power), .sample_o(sample),
      .trial_code_o(trial), .conv_mode_o(mode), .conversion_done_irq_o(irq));

   adm_comparator_model cmp_model (.clk_i(clk_i), .vin_i(vin), .power_i(power),
      .trial_i(trial), .compare_o(cmp));

   ////////////////////////////////////////////////////////////////////////////
   // checks and bus tasks
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkn(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask

   task automatic wr_reg(input logic [19:0] a, input logic [7:0] v);
      @(posedge clk_i);
      #2;
      addr  = a;
      wdata = v;
      wr    = 1'b1;
      @(posedge clk_i);
      #2;
      wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [19:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      #2;
      addr = a;
      rd   = 1'b1;
      @(posedge clk_i);
      #2;
      rd = 1'b0;
      @(posedge clk_i);
      #2;
      chk8(rdata, exp);
   endtask

   task automatic settle;
      repeat (5) @(posedge clk_i);
      #2;
   endtask

   // start a conversion, count cycles to the done pulse and sampling cycles
   task automatic convert(input logic [7:0] ctrl);
      cyc = 0;
      smp = 0;
      wr_reg(ADM_CTRL_ADDR, ctrl);
      while (irq !== 1'b1 && cyc < 400) begin
         @(posedge clk_i);
         #1;
         cyc++;
         if (sample === 1'b1) smp++;
      end
   endtask

   task automatic end_of_test;
      if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // tests
   initial begin
      repeat (6) @(posedge clk_i);
      #2;
      reset_i = 1'b0;
      rd_reg(ADM_RESULT_HI_ADDR, 8'h00);
      rd_reg(ADM_RES_SEL_ADDR, 8'h00);
      rd_reg(20'hfff40, 8'h00);
      chk8({7'h0, power}, 8'h00);
      wr_reg(ADM_CTRL_ADDR, 8'h80);
      rd_reg(ADM_CTRL_ADDR, 8'h00);
      chk8({6'h0, mode}, 8'h00);
      // enable first, then wait before start
      wr_reg(ADM_CTRL_ADDR, 8'h01);
      settle();
      chk8({6'h0, mode}, 8'h01);
      chk8({7'h0, power}, 8'h01);
      for (int i = 0; i < 4; i++) begin
         d   = 8 >> i;
         vin = 10'h2b5 + 10'(i * 97);
         wr_reg(ADM_CTRL_ADDR, {2'b00, 2'(i), 4'h1});
         convert({2'b10, 2'(i), 4'h1});
         // 2 state fad + 19 fad; undivided clock loses the idle tick
         chkn(cyc, 21 * d, 21 * d + 1);
         chkn(smp, 7 * d, 7 * d);
         chk8({6'h0, mode}, 8'h01);
         rd_reg(ADM_RESULT_HI_ADDR, vin[9:2]);
         rd_reg(ADM_RESULT_LO_ADDR, {vin[1:0], 6'h00});
      end
      // short sampling, undivided clock
      vin = 10'h0c3;
      wr_reg(ADM_CTRL_ADDR, 8'h39);
      convert(8'hb9);
      chkn(cyc, 20, 20);
      chkn(smp, 5, 5);
      rd_reg(ADM_RESULT_LO_ADDR, 8'hc0);
      // 8-bit resolution, set only while stopped
      // start already dropped at conversion end, then enable drops
      wr_reg(ADM_CTRL_ADDR, 8'h00);
      wr_reg(ADM_RES_SEL_ADDR, 8'hff);
      rd_reg(ADM_RES_SEL_ADDR, 8'h01);
      vin = 10'h1ff;
      wr_reg(ADM_CTRL_ADDR, 8'h31);
      settle();
      convert(8'hb1);
      chkn(cyc, 20, 20);
      rd_reg(ADM_RESULT_HI_ADDR, 8'h7f);
      rd_reg(ADM_RESULT_LO_ADDR, 8'h00);
      wr_reg(ADM_CTRL_ADDR, 8'h00);
      wr_reg(ADM_RES_SEL_ADDR, 8'h00);
      // abort in mid-conversion
      vin = 10'h3ff;
      wr_reg(ADM_CTRL_ADDR, 8'h31);
      settle();
      wr_reg(ADM_CTRL_ADDR, 8'hb1);
      repeat (8) @(posedge clk_i);
      wr_reg(ADM_CTRL_ADDR, 8'h31);
      seen = 1'b0;
      repeat (60) begin
         @(posedge clk_i);
         #1;
         seen = seen | (irq !== 1'b0);
      end
      chk8({7'h0, seen}, 8'h00);
      chk8({6'h0, mode}, 8'h01);
      rd_reg(ADM_RESULT_HI_ADDR, 8'h7f);
      wr_reg(ADM_RESULT_HI_ADDR, 8'hff);
      rd_reg(ADM_RESULT_HI_ADDR, 8'h7f);
      wr_reg(ADM_CTRL_ADDR, 8'h00);
      settle();
      chk8({7'h0, power}, 8'h00);
      end_of_test();
   end

   initial begin
      #(25 * 20000);
      n_mismatch++;
      end_of_test();
   end
endmodule
